// [core/gcr_register_bank.sv]
// Configuration and status register bank of the serial gateway
module gcr_register_bank (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [16:0] regNumber,
	input  wire logic [15:0] regWriteData,
	output logic      [15:0] regReadData,
	output logic             regReadValid,
	input  wire logic [3:0]  bitrateSwitch,
	input  wire logic [3:0]  frameSwitch,
	input  wire logic [3:0]  modeSwitch,
	input  wire logic [15:0] partnerInputSize,
	input  wire logic [15:0] partnerOutputSize,
	input  wire logic [15:0] partnerModuleType,
	input  wire logic [15:0] partnerBusState,
	output logic             restartPulse,
	output logic      [1:0]  activeElecMode,
	output logic             activeFailsafe,
	output logic             activeTermination,
	output logic      [7:0]  activeNodeAddress,
	output logic      [3:0]  activeBitrate,
	output logic      [3:0]  activeFrame,
	output logic             activeDefaults
);
	typedef enum logic [1:0] {
		SETTLE,
		APPLY,
		RUN
	} gcr_state_t;

	gcr_mode_if modeBus ();

	gcr_mode_decode modeDecoder (
		.modeBus (modeBus.decoder)
	);

	// Switch pins are asynchronous: two flops before any use
	logic [11:0] switchMeta_reg;
	logic [11:0] switchSync_reg;

	// Pending node address kept as two bytes, low byte first
	logic [7:0]  nodeBytes_reg  [2];
	logic [7:0]  nodeBytes_next [2];

	gcr_state_t  state_reg;
	gcr_state_t  state_next;
	logic [1:0]  settle_reg;
	logic [1:0]  settle_next;
	logic        restart_reg;
	logic        restart_next;
	logic [1:0]  elec_reg;
	logic [1:0]  elec_next;
	logic        failsafe_reg;
	logic        failsafe_next;
	logic        term_reg;
	logic        term_next;
	logic [3:0]  modeRep_reg;
	logic [3:0]  modeRep_next;
	logic [7:0]  nodeAct_reg;
	logic [7:0]  nodeAct_next;
	logic [3:0]  bitrate_reg;
	logic [3:0]  bitrate_next;
	logic [3:0]  frame_reg;
	logic [3:0]  frame_next;
	logic        defaults_reg;
	logic        defaults_next;
	logic [15:0] rdData_reg;
	logic [15:0] rdData_next;
	logic        rdValid_reg;
	logic        rdValid_next;

	logic [3:0]  syncBitrate;
	logic [3:0]  syncFrame;
	logic        nodeWriteOk;
	logic        keyWrite;

	// Assembles a sixteen-bit value from its little-endian byte pair
	function automatic logic [15:0] gcr_word(input logic [7:0] lowByte, input logic [7:0] highByte);
		gcr_word = {highByte, lowByte};
	endfunction : gcr_word

	assign syncBitrate      = switchSync_reg[3:0];
	assign syncFrame        = switchSync_reg[7:4];
	assign modeBus.modeCode = switchSync_reg[11:8];

	assign keyWrite    = regWrite && regNumber == gcr_pkg::REG_SW_RESTART &&
		regWriteData == gcr_pkg::RESTART_KEY;
	assign nodeWriteOk = regWrite && regNumber == gcr_pkg::REG_NODE_ADDRESS &&
		regWriteData[15:8] == 8'h00 &&
		regWriteData[7:0] >= gcr_pkg::NODE_ADDR_MIN &&
		regWriteData[7:0] <= gcr_pkg::NODE_ADDR_MAX;

	always_comb begin
		state_next        = state_reg;
		settle_next       = settle_reg;
		restart_next      = 1'b0;
		elec_next         = elec_reg;
		failsafe_next     = failsafe_reg;
		term_next         = term_reg;
		modeRep_next      = modeRep_reg;
		nodeAct_next      = nodeAct_reg;
		bitrate_next      = bitrate_reg;
		frame_next        = frame_reg;
		defaults_next     = defaults_reg;
		nodeBytes_next[0] = nodeBytes_reg[0];
		nodeBytes_next[1] = nodeBytes_reg[1];

		// Only the node address is stored; every other write except the restart key falls away
		if (nodeWriteOk) begin
			nodeBytes_next[0] = regWriteData[7:0];
			nodeBytes_next[1] = regWriteData[15:8];
		end

		unique case (state_reg)
			SETTLE: begin
				// Waits out the synchroniser so the first capture sees real pins
				settle_next = settle_reg + 2'h1;
				if (settle_reg == gcr_pkg::SETTLE_CYCLES) begin
					state_next = APPLY;
				end
			end
			APPLY: begin
				// Pending and switch settings become active only here
				state_next    = RUN;
				nodeAct_next  = nodeBytes_reg[0];
				elec_next     = modeBus.elecMode;
				failsafe_next = modeBus.failsafeOn;
				term_next     = modeBus.terminationOn;
				modeRep_next  = modeBus.reportCode;
				defaults_next = 1'b0;
				if (syncBitrate == gcr_pkg::BITRATE_DEFAULT_SEL) begin
					bitrate_next  = gcr_pkg::BITRATE_DEFAULT;
					frame_next    = gcr_pkg::FRAME_DEFAULT;
					defaults_next = 1'b1;
					nodeAct_next  = gcr_pkg::NODE_ADDR_RESET;
				end else begin
					bitrate_next = syncBitrate > gcr_pkg::BITRATE_MAX_CODE ?
						gcr_pkg::BITRATE_SCRIPT : syncBitrate;
					frame_next   = syncFrame > gcr_pkg::FRAME_MAX_CODE ?
						gcr_pkg::FRAME_DEFAULT : syncFrame;
				end
			end
			RUN: begin
				if (keyWrite) begin
					restart_next = 1'b1;
					state_next   = APPLY;
				end
			end
		endcase
	end

	always_comb begin
		rdValid_next = regRead;
		rdData_next  = 16'h0000;
		// Reads of unimplemented numbers answer zero
		if (regRead) begin
			unique case (regNumber)
				gcr_pkg::REG_CUR_BITRATE:     rdData_next = {12'h000, bitrate_reg};
				gcr_pkg::REG_CUR_FRAME:       rdData_next = {12'h000, frame_reg};
				gcr_pkg::REG_ELEC_MODE:       rdData_next = {12'h000, modeRep_reg};
				gcr_pkg::REG_NODE_ADDRESS:    rdData_next = gcr_word(nodeBytes_reg[0],
					nodeBytes_reg[1]);
				gcr_pkg::REG_DEFAULTS_IN_USE: rdData_next = {15'h0000, defaults_reg};
				gcr_pkg::REG_PARTNER_IN_SIZE: rdData_next = partnerInputSize;
				gcr_pkg::REG_PARTNER_OUT_SZ:  rdData_next = partnerOutputSize;
				gcr_pkg::REG_PARTNER_TYPE:    rdData_next = partnerModuleType;
				gcr_pkg::REG_PARTNER_STATE:   rdData_next = partnerBusState;
				default:                      rdData_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			switchMeta_reg   <= 12'h000;
			switchSync_reg   <= 12'h000;
			nodeBytes_reg[0] <= gcr_pkg::NODE_ADDR_RESET;
			nodeBytes_reg[1] <= 8'h00;
			state_reg        <= SETTLE;
			settle_reg       <= 2'h0;
			restart_reg      <= 1'b0;
			elec_reg         <= 2'h0;
			failsafe_reg     <= 1'b0;
			term_reg         <= 1'b0;
			modeRep_reg      <= 4'h0;
			nodeAct_reg      <= gcr_pkg::NODE_ADDR_RESET;
			bitrate_reg      <= gcr_pkg::BITRATE_DEFAULT;
			frame_reg        <= gcr_pkg::FRAME_DEFAULT;
			defaults_reg     <= 1'b0;
			rdData_reg       <= 16'h0000;
			rdValid_reg      <= 1'b0;
		end else begin
			switchMeta_reg   <= {modeSwitch, frameSwitch, bitrateSwitch};
			switchSync_reg   <= switchMeta_reg;
			nodeBytes_reg[0] <= nodeBytes_next[0];
			nodeBytes_reg[1] <= nodeBytes_next[1];
			state_reg        <= state_next;
			settle_reg       <= settle_next;
			restart_reg      <= restart_next;
			elec_reg         <= elec_next;
			failsafe_reg     <= failsafe_next;
			term_reg         <= term_next;
			modeRep_reg      <= modeRep_next;
			nodeAct_reg      <= nodeAct_next;
			bitrate_reg      <= bitrate_next;
			frame_reg        <= frame_next;
			defaults_reg     <= defaults_next;
			rdData_reg       <= rdData_next;
			rdValid_reg      <= rdValid_next;
		end
	end

	assign regReadData       = rdData_reg;
	assign regReadValid      = rdValid_reg;
	assign restartPulse      = restart_reg;
	assign activeElecMode    = elec_reg;
	assign activeFailsafe    = failsafe_reg;
	assign activeTermination = term_reg;
	assign activeNodeAddress = nodeAct_reg;
	assign activeBitrate     = bitrate_reg;
	assign activeFrame       = frame_reg;
	assign activeDefaults    = defaults_reg;
endmodule : gcr_register_bank

// [core/gcr_pkg.sv]
// Package of register numbers, field codes and reset values for the gateway register bank
package gcr_pkg;
	localparam logic [16:0] REG_SW_RESTART      = 17'h01000;
	localparam logic [16:0] REG_CUR_BITRATE     = 17'h01001;
	localparam logic [16:0] REG_CUR_FRAME       = 17'h01002;
	localparam logic [16:0] REG_ELEC_MODE       = 17'h01003;
	localparam logic [16:0] REG_NODE_ADDRESS    = 17'h01004;
	localparam logic [16:0] REG_DEFAULTS_IN_USE = 17'h01005;
	localparam logic [16:0] REG_PARTNER_IN_SIZE = 17'h01006;
	localparam logic [16:0] REG_PARTNER_OUT_SZ  = 17'h01007;
	localparam logic [16:0] REG_PARTNER_TYPE    = 17'h01008;
	localparam logic [16:0] REG_PARTNER_STATE   = 17'h01009;
	localparam logic [16:0] REG_NUM_MIN         = 17'h00001;
	localparam logic [16:0] REG_NUM_MAX         = 17'h10000;

	localparam logic [15:0] RESTART_KEY         = 16'h4b42;
	localparam logic [7:0]  NODE_ADDR_MIN       = 8'h01;
	localparam logic [7:0]  NODE_ADDR_MAX       = 8'hf9;
	localparam logic [7:0]  NODE_ADDR_RESET     = 8'h01;

	localparam logic [3:0]  BITRATE_SCRIPT      = 4'h0;
	localparam logic [3:0]  BITRATE_MAX_CODE    = 4'h8;
	localparam logic [3:0]  BITRATE_DEFAULT_SEL = 4'h9;
	localparam logic [3:0]  BITRATE_DEFAULT     = 4'h3;
	localparam logic [3:0]  FRAME_MAX_CODE      = 4'h5;
	localparam logic [3:0]  FRAME_DEFAULT       = 4'h0;
	localparam logic [3:0]  MODE_MAX_CODE       = 4'h9;
	localparam logic [3:0]  MODE_ALIAS_232      = 4'h9;
	localparam logic [3:0]  MODE_485_FIRST      = 4'h1;
	localparam logic [3:0]  MODE_485_LAST       = 4'h4;
	localparam logic [3:0]  MODE_422_FIRST      = 4'h5;
	localparam logic [3:0]  MODE_422_LAST       = 4'h8;

	localparam logic [1:0]  SETTLE_CYCLES       = 2'h3;

	typedef enum logic [1:0] {
		ELEC_RS232,
		ELEC_RS485,
		ELEC_RS422
	} gcr_elec_t;
endpackage : gcr_pkg

// [core/gcr_mode_if.sv]
// Interface carrying the mode setting to its decoder and the decoded line options back
interface gcr_mode_if;
	logic [3:0]         modeCode;
	gcr_pkg::gcr_elec_t elecMode;
	logic               failsafeOn;
	logic               terminationOn;
	logic [3:0]         reportCode;

	modport owner (output modeCode, input elecMode, failsafeOn, terminationOn, reportCode);
	modport decoder (input modeCode, output elecMode, failsafeOn, terminationOn, reportCode);
endinterface : gcr_mode_if

// [core/gcr_mode_decode.sv]
// Decoder of the interface-mode rotary setting into electrical mode and line options
module gcr_mode_decode (
	gcr_mode_if.decoder modeBus
);
	logic [3:0] offset;

	always_comb begin
		offset                = 4'h0;
		modeBus.elecMode      = gcr_pkg::ELEC_RS232;
		modeBus.failsafeOn    = 1'b0;
		modeBus.terminationOn = 1'b0;
		modeBus.reportCode    = modeBus.modeCode;
		if (modeBus.modeCode >= gcr_pkg::MODE_485_FIRST &&
			modeBus.modeCode <= gcr_pkg::MODE_485_LAST) begin
			offset                = modeBus.modeCode - gcr_pkg::MODE_485_FIRST;
			modeBus.elecMode      = gcr_pkg::ELEC_RS485;
			modeBus.terminationOn = offset[0];
			modeBus.failsafeOn    = offset[1];
		end else if (modeBus.modeCode >= gcr_pkg::MODE_422_FIRST &&
			modeBus.modeCode <= gcr_pkg::MODE_422_LAST) begin
			offset                = modeBus.modeCode - gcr_pkg::MODE_422_FIRST;
			modeBus.elecMode      = gcr_pkg::ELEC_RS422;
			modeBus.terminationOn = offset[0];
			modeBus.failsafeOn    = offset[1];
		end else if (modeBus.modeCode > gcr_pkg::MODE_MAX_CODE) begin
			// A switch code the rotary cannot produce is handled as zero
			modeBus.reportCode    = 4'h0;
		end
		// Zero and nine both fall through to RS-232 with both options off
	end
endmodule : gcr_mode_decode

// [test/gcr_master_model.sv]
// Fieldbus master model that drives the register port of the bank
module gcr_master_model (
	input  wire logic        clk,
	output logic             regWrite,
	output logic             regRead,
	output logic      [16:0] regNumber,
	output logic      [15:0] regWriteData,
	input  wire logic [15:0] regReadData,
	input  wire logic        regReadValid
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regNumber = 17'h00000;
		regWriteData = 16'h0000;
	end
	// Low byte travels in bits 7:0, matching the stored byte order
	task automatic wr(input logic [16:0] n, input logic [15:0] d);
		// An idle edge first, so a strobe never falls and rises in one time step
		@(posedge clk);
		#1;
		regNumber = n;
		regWriteData = d;
		regWrite = 1'b1;
		@(posedge clk);
		#1;
		regWrite = 1'b0;
		// Released lines flip so a stale value is never mistaken for a request
		regNumber = ~n;
		regWriteData = ~d;
	endtask : wr
	task automatic rd(input logic [16:0] n, output logic [15:0] d, output logic v);
		@(posedge clk);
		#1;
		regNumber = n;
		regRead = 1'b1;
		@(posedge clk);
		#1;
		regRead = 1'b0;
		regNumber = ~n;
		d = regReadData;
		v = regReadValid;
	endtask : rd
endmodule : gcr_master_model

// [test/gcr_register_bank_sva.sv]
// Assertions on the ports of the register bank
module gcr_register_bank_sva (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [16:0] regNumber,
	input wire logic [15:0] regWriteData,
	input wire logic [15:0] regReadData,
	input wire logic        regReadValid,
	input wire logic [15:0] partnerInputSize,
	input wire logic        restartPulse,
	input wire logic [1:0]  activeElecMode,
	input wire logic        activeFailsafe,
	input wire logic        activeTermination,
	input wire logic [7:0]  activeNodeAddress,
	input wire logic [3:0]  activeBitrate,
	input wire logic [3:0]  activeFrame,
	input wire logic        activeDefaults
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Start-up capture changes the outputs without a pulse, so it is skipped
	logic [3:0]  runCnt;
	logic [20:0] act;
	assign act = {activeNodeAddress, activeBitrate, activeFrame, activeElecMode,
		activeFailsafe, activeTermination, activeDefaults};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			runCnt <= 4'h0;
		end else if (runCnt != 4'hf) begin
			runCnt <= runCnt + 4'h1;
		end
	end
	property p_ans; regRead |=> regReadValid; endproperty
	a_ans: assert property (p_ans) else $error("read not answered");
	property p_idle; !regRead |=> !regReadValid && regReadData == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	property p_key; restartPulse |-> $past(regWrite)
		&& $past(regNumber) == gcr_pkg::REG_SW_RESTART
		&& $past(regWriteData) == gcr_pkg::RESTART_KEY; endproperty
	a_key: assert property (p_key) else $error("restart without key");
	property p_pulse; restartPulse |=> !restartPulse; endproperty
	a_pulse: assert property (p_pulse) else $error("restart pulse too long");
	property p_hold; runCnt > 4'h8 && !$past(restartPulse) |-> $stable(act); endproperty
	a_hold: assert property (p_hold) else $error("active value moved without restart");
	property p_v24; activeElecMode == 2'h0 |-> !activeFailsafe && !activeTermination; endproperty
	a_v24: assert property (p_v24) else $error("line option in RS-232");
	property p_range; activeBitrate <= gcr_pkg::BITRATE_MAX_CODE
		&& activeFrame <= gcr_pkg::FRAME_MAX_CODE; endproperty
	a_range: assert property (p_range) else $error("rate or frame code out of range");
	property p_node; activeNodeAddress >= gcr_pkg::NODE_ADDR_MIN
		&& activeNodeAddress <= gcr_pkg::NODE_ADDR_MAX; endproperty
	a_node: assert property (p_node) else $error("node address out of range");
	property p_dflt; activeDefaults |-> activeBitrate == gcr_pkg::BITRATE_DEFAULT
		&& activeFrame == gcr_pkg::FRAME_DEFAULT
		&& activeNodeAddress == gcr_pkg::NODE_ADDR_RESET; endproperty
	a_dflt: assert property (p_dflt) else $error("defaults flag without defaults");
	property p_part; regRead && regNumber == gcr_pkg::REG_PARTNER_IN_SIZE
		|=> regReadData == $past(partnerInputSize); endproperty
	a_part: assert property (p_part) else $error("partner size read wrong");
	property p_rate; regRead && regNumber == gcr_pkg::REG_CUR_BITRATE
		|=> regReadData == {12'h000, $past(activeBitrate)}; endproperty
	a_rate: assert property (p_rate) else $error("bitrate read not active value");
	c_restart: cover property (restartPulse);
	c_dflt: cover property (activeDefaults);
	c_rs422: cover property (activeElecMode == 2'h2 && activeFailsafe && activeTermination);
endmodule : gcr_register_bank_sva
bind gcr_register_bank gcr_register_bank_sva gcr_register_bank_sva_i (.clk, .rst_n,
	.regWrite, .regRead, .regNumber, .regWriteData, .regReadData, .regReadValid,
	.partnerInputSize, .restartPulse, .activeElecMode, .activeFailsafe, .activeTermination,
	.activeNodeAddress, .activeBitrate, .activeFrame, .activeDefaults);

// [test/gcr_register_bank_tb.sv]
// Self-checking bench for the gateway register bank
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module gcr_register_bank_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst_n, regWrite, regRead, regReadValid, restartPulse;
	logic        activeFailsafe, activeTermination, activeDefaults;
	logic [16:0] regNumber;
	logic [15:0] regWriteData, regReadData;
	logic [15:0] partnerInputSize, partnerOutputSize, partnerModuleType, partnerBusState;
	logic [3:0]  bitrateSwitch, frameSwitch, modeSwitch, activeBitrate, activeFrame, c;
	logic [1:0]  activeElecMode, em;
	logic [7:0]  activeNodeAddress;
	integer      miscompares, checkCount;
	gcr_register_bank gcr_register_bank_i (.clk, .rst_n, .regWrite, .regRead, .regNumber,
		.regWriteData, .regReadData, .regReadValid, .bitrateSwitch, .frameSwitch, .modeSwitch,
		.partnerInputSize, .partnerOutputSize, .partnerModuleType, .partnerBusState,
		.restartPulse, .activeElecMode, .activeFailsafe, .activeTermination,
		.activeNodeAddress, .activeBitrate, .activeFrame, .activeDefaults);
	gcr_master_model gcr_master_model_i (.clk, .regWrite, .regRead, .regNumber,
		.regWriteData, .regReadData, .regReadValid);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic rdc(input string n, input logic [16:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic        v;
		gcr_master_model_i.rd(a, d, v);
		`CHK(n, 1'b1, v)
		`CHK(n, e, d)
	endtask : rdc
	task automatic wrn(input logic [15:0] d);
		gcr_master_model_i.wr(gcr_pkg::REG_NODE_ADDRESS, d);
	endtask : wrn
	task automatic restart(input logic [15:0] key, input logic e);
		gcr_master_model_i.wr(gcr_pkg::REG_SW_RESTART, key);
		`CHK("restartPulse", e, restartPulse)
		repeat (2) @(posedge clk);
		#1;
	endtask : restart
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	// A hang counts as a mismatch and still reaches the verdict
	initial begin
		#500000;
		miscompares++;
		finish_test();
	end
	initial begin
		miscompares = 0;
		checkCount = 0;
		rst_n = 1'b0;
		bitrateSwitch = 4'h9;
		frameSwitch = 4'h2;
		modeSwitch = 4'h9;
		partnerInputSize = 16'h1234;
		partnerOutputSize = 16'h0a0b;
		partnerModuleType = 16'h5a3c;
		partnerBusState = 16'h00c3;
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		`CHK("dfltAct", 1'b1, activeDefaults)
		`CHK("modeAct", 2'h0, activeElecMode)
		rdc("rate", gcr_pkg::REG_CUR_BITRATE, 16'h0003);
		rdc("frame", gcr_pkg::REG_CUR_FRAME, 16'h0000);
		rdc("elec", gcr_pkg::REG_ELEC_MODE, 16'h0009);
		rdc("dflt", gcr_pkg::REG_DEFAULTS_IN_USE, 16'h0001);
		rdc("restart", gcr_pkg::REG_SW_RESTART, 16'h0000);
		rdc("low", 17'h00001, 16'h0000);
		rdc("high", gcr_pkg::REG_NUM_MAX, 16'h0000);
		rdc("pIn", gcr_pkg::REG_PARTNER_IN_SIZE, 16'h1234);
		rdc("pOut", gcr_pkg::REG_PARTNER_OUT_SZ, 16'h0a0b);
		rdc("pType", gcr_pkg::REG_PARTNER_TYPE, 16'h5a3c);
		rdc("pState", gcr_pkg::REG_PARTNER_STATE, 16'h00c3);
		wrn(16'h0005);
		rdc("node", gcr_pkg::REG_NODE_ADDRESS, 16'h0005);
		`CHK("nodeAct", 8'h01, activeNodeAddress)
		wrn(16'h00fa);
		wrn(16'h0000);
		wrn(16'h01f9);
		rdc("node", gcr_pkg::REG_NODE_ADDRESS, 16'h0005);
		wrn(16'h00f9);
		rdc("node", gcr_pkg::REG_NODE_ADDRESS, 16'h00f9);
		gcr_master_model_i.wr(gcr_pkg::REG_CUR_BITRATE, 16'h0007);
		gcr_master_model_i.wr(gcr_pkg::REG_DEFAULTS_IN_USE, 16'h0000);
		rdc("rate", gcr_pkg::REG_CUR_BITRATE, 16'h0003);
		rdc("dflt", gcr_pkg::REG_DEFAULTS_IN_USE, 16'h0001);
		restart(16'h4b43, 1'b0);
		`CHK("nodeAct", 8'h01, activeNodeAddress)
		for (int m = 0; m < 10; m++) begin
			c = 4'(m);
			bitrateSwitch = c;
			frameSwitch = c;
			modeSwitch = c;
			repeat (3) @(posedge clk);
			#1;
			rdc("elecOld", gcr_pkg::REG_ELEC_MODE, (m == 0) ? 16'h0009 : 16'(m - 1));
			restart(gcr_pkg::RESTART_KEY, 1'b1);
			em = (c == 4'h0 || c == 4'h9) ? 2'h0 : ((c <= 4'h4) ? 2'h1 : 2'h2);
			`CHK("mode", em, activeElecMode)
			`CHK("fsafe", (c inside {4'h3, 4'h4, 4'h7, 4'h8}), activeFailsafe)
			`CHK("term", (c inside {4'h2, 4'h4, 4'h6, 4'h8}), activeTermination)
			`CHK("rateAct", (c == 4'h9) ? 4'h3 : c, activeBitrate)
			`CHK("frameAct", (c > 4'h5) ? 4'h0 : c, activeFrame)
			`CHK("dfltAct", c == 4'h9, activeDefaults)
			`CHK("nodeAct", (c == 4'h9) ? 8'h01 : 8'hf9, activeNodeAddress)
			rdc("elec", gcr_pkg::REG_ELEC_MODE, {12'h000, c});
		end
		// Codes the switches should never show fall back to RS-232 and script rate
		bitrateSwitch = 4'ha;
		frameSwitch = 4'h6;
		modeSwitch = 4'ha;
		repeat (3) @(posedge clk);
		#1;
		restart(gcr_pkg::RESTART_KEY, 1'b1);
		`CHK("modeBad", 2'h0, activeElecMode)
		`CHK("fsafeBad", 1'b0, activeFailsafe)
		`CHK("termBad", 1'b0, activeTermination)
		`CHK("rateBad", 4'h0, activeBitrate)
		`CHK("frameBad", 4'h0, activeFrame)
		`CHK("dfltBad", 1'b0, activeDefaults)
		`CHK("nodeBad", 8'hf9, activeNodeAddress)
		rdc("elecBad", gcr_pkg::REG_ELEC_MODE, 16'h0000);
		finish_test();
	end
endmodule : gcr_register_bank_tb
